/* tks_pkg.sv */
// shared constants and types for the touch key signal processor
package tks_pkg;

  localparam int          NUM_KEYS     = 4;
  localparam int          RAW_W        = 12;
  localparam int          TIMER_W      = 32;
  localparam int          CLK_HZ       = 10_000_000;
  localparam int          CAL_TIME_MS  = 1000;
  localparam int          CAL_CYC      = CAL_TIME_MS * (CLK_HZ / 1000);
  localparam int          TOUT_SHORT_S = 10;
  localparam int          TOUT_LONG_S  = 60;
  localparam int          TOUT_SHORT_CYC = TOUT_SHORT_S * CLK_HZ;
  localparam int          TOUT_LONG_CYC  = TOUT_LONG_S * CLK_HZ;
  localparam int          DRIFT_UP_RATE = 10;
  localparam int          DRIFT_DN_RATE = 1;
  localparam int          DRIFT_UP_CYC  = CLK_HZ / DRIFT_UP_RATE;
  localparam int          DRIFT_DN_CYC  = CLK_HZ / DRIFT_DN_RATE;
  localparam logic [11:0] THRESH       = 12'h004;
  localparam logic [11:0] HYST         = THRESH >> 2;
  localparam logic [11:0] BURST_MAX    = 12'hFFF;
  localparam logic [1:0]  INTEG_LAST   = 2'h2;
  localparam logic [2:0]  RECAL_BURSTS = 3'h4;
  localparam logic [1:0]  ROLL_ONE     = 2'h1;
  localparam logic [1:0]  ROLL_TWO     = 2'h2;
  localparam logic [1:0]  KEY_FIRST    = 2'h0;
  localparam logic [1:0]  KEY_LAST     = 2'h3;
  localparam logic [3:0]  X_IDLE       = 4'h0;

  typedef enum logic [2:0] {
    ST_DISCH,
    ST_CHG,
    ST_XHI,
    ST_XFER,
    ST_XLO,
    ST_PROC
  } tks_state_t;

  typedef struct packed {
    logic [11:0] ref_lvl;
    logic [1:0]  integ;
    logic        det;
    logic [2:0]  recal;
  } tks_key_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } tks_sw_t;

endpackage

/* tks_touch_key_signal_processor.sv */
// touch key signal processor: burst acquisition, calibration, drift, detection, rollover
// Notes on behaviour
// - power-up scans all keys, sets own references
// - calibration lasts about one second first
// - reference tracks signal, frozen while detecting
// - slew limited; threshold follows reference
// - rising signal tracked faster than falling
// - threshold fixed offset below reference
// - release needs rise of quarter delta
// - per-key on-timer forces full recalibration
// - after timeout key detects against new reference
// - timeout on one key leaves others alone
// - timeout 10 s grounded, 60 s high
// - three consecutive low samples confirm detection
// - non-detect sample clears integrator at once
// - grounded rollover pin reports one key
// - high rollover pin reports up to two
// - four active-high touch outputs
// - drive lines released during reset and until the first enabled clock after it
// - burst counts transfer cycles until trip
// - first detected keys keep outputs, up to the rollover limit
// - touch judged from burst against reference
`timescale 1ns/1ps
`default_nettype none
module tks_touch_key_signal_processor
  import tks_pkg::*;
#(
  parameter int unsigned CAL_CYCLES   = CAL_CYC,
  parameter int unsigned TOUT_SHORT   = TOUT_SHORT_CYC,
  parameter int unsigned TOUT_LONG    = TOUT_LONG_CYC,
  parameter int unsigned DRIFT_UP_PER = DRIFT_UP_CYC,
  parameter int unsigned DRIFT_DN_PER = DRIFT_DN_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       cs_trip,
  input  wire logic       rollover_select_pin,
  input  wire logic       timeout_select_pin,
  output logic [3:0]      x_drive,
  output logic            x_oe_n,
  output logic            sw_s1,
  output logic            sw_s2,
  output logic            sw_s3,
  output logic [3:0]      key_out
);

  // pin synchronisers: bit 0 trip, 1 rollover, 2 timeout
  logic [2:0]  pin_s1_ff;
  logic [2:0]  pin_s2_ff;

  tks_state_t  st_ff;
  tks_state_t  nxt_st;
  logic [1:0]  sel_ff;
  logic [1:0]  nxt_sel;
  logic [11:0] burst_ff;
  logic [11:0] nxt_burst;
  logic        cal_done_ff;
  logic        nxt_cal_done;
  logic [31:0] cal_cnt_ff;
  logic [31:0] nxt_cal_cnt;

  tks_key_t    key_ff   [NUM_KEYS];
  tks_key_t    nxt_key  [NUM_KEYS];
  logic [31:0] on_ff    [NUM_KEYS];
  logic [31:0] nxt_on   [NUM_KEYS];
  logic [3:0]  up_due_ff;
  logic [3:0]  nxt_up_due;
  logic [3:0]  dn_due_ff;
  logic [3:0]  nxt_dn_due;
  logic [31:0] up_cnt_ff;
  logic [31:0] nxt_up_cnt;
  logic [31:0] dn_cnt_ff;
  logic [31:0] nxt_dn_cnt;

  logic [3:0]  rep_ff;
  logic [3:0]  nxt_rep;
  logic [3:0]  x_ff;
  logic [3:0]  nxt_x;
  tks_sw_t     sw_ff;
  tks_sw_t     nxt_sw;
  logic        oe_n_ff;

  logic        trip;
  logic        roll_two;
  logic        tout_long;
  assign trip      = pin_s2_ff[0];
  assign roll_two  = pin_s2_ff[1];
  assign tout_long = pin_s2_ff[2];

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_s1_ff <= 3'h0;
      pin_s2_ff <= 3'h0;
    end else if (clk_en) begin
      pin_s1_ff <= {timeout_select_pin, rollover_select_pin, cs_trip};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // acquisition sequencer and calibration timer
  always_comb begin
    nxt_st       = st_ff;
    nxt_sel      = sel_ff;
    nxt_burst    = burst_ff;
    nxt_cal_cnt  = cal_cnt_ff;
    nxt_cal_done = cal_done_ff;
    if (!cal_done_ff) begin
      if (cal_cnt_ff >= CAL_CYCLES - 1) begin
        nxt_cal_done = 1'b1;
      end else begin
        nxt_cal_cnt = cal_cnt_ff + 32'h1;
      end
    end
    case (st_ff)
      ST_DISCH: begin
        // hold discharge until the synchronised trip has fallen; a stale trip
        // left from the last burst would otherwise end the next one at zero
        nxt_burst = 12'h000;
        if (!trip) begin
          nxt_st = ST_CHG;
        end
      end
      ST_CHG: begin
        // the trip lags two clocks through the synchroniser, under one cycle
        if (trip || burst_ff == BURST_MAX) begin
          nxt_st = ST_PROC;
        end else begin
          nxt_st = ST_XHI;
        end
      end
      ST_XHI:  nxt_st = ST_XFER;
      ST_XFER: nxt_st = ST_XLO;
      ST_XLO: begin
        nxt_burst = burst_ff + 12'h001;
        nxt_st    = ST_CHG;
      end
      ST_PROC: begin
        nxt_sel = sel_ff + 2'h1;
        nxt_st  = ST_DISCH;
      end
      default: nxt_st = ST_DISCH;
    endcase
    nxt_sw.s3 = (nxt_st == ST_DISCH);
    nxt_sw.s1 = (nxt_st == ST_CHG) || (nxt_st == ST_XHI);
    nxt_sw.s2 = (nxt_st == ST_XFER) || (nxt_st == ST_XLO);
    nxt_x     = X_IDLE;
    if (nxt_st == ST_XHI || nxt_st == ST_XFER) begin
      nxt_x[nxt_sel] = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_ff       <= ST_DISCH;
      sel_ff      <= KEY_FIRST;
      burst_ff    <= 12'h000;
      cal_cnt_ff  <= 32'h0;
      cal_done_ff <= 1'b0;
      sw_ff       <= '0;
      x_ff        <= X_IDLE;
      oe_n_ff     <= 1'b1;
    end else if (clk_en) begin
      st_ff       <= nxt_st;
      sel_ff      <= nxt_sel;
      burst_ff    <= nxt_burst;
      cal_cnt_ff  <= nxt_cal_cnt;
      cal_done_ff <= nxt_cal_done;
      sw_ff       <= nxt_sw;
      x_ff        <= nxt_x;
      oe_n_ff     <= 1'b0;
    end
  end

  // per-key processing, drift, on-duration timers and rollover
  always_comb begin
    tks_key_t    k;
    logic [11:0] thr;
    logic [1:0]  cnt;
    logic [1:0]  lim;
    logic [31:0] tout;
    k    = '0;
    thr  = 12'h000;
    cnt  = 2'h0;
    lim  = roll_two ? ROLL_TWO : ROLL_ONE;
    tout = tout_long ? TOUT_LONG : TOUT_SHORT;
    nxt_up_cnt = (up_cnt_ff >= DRIFT_UP_PER - 1) ? 32'h0 : up_cnt_ff + 32'h1;
    nxt_dn_cnt = (dn_cnt_ff >= DRIFT_DN_PER - 1) ? 32'h0 : dn_cnt_ff + 32'h1;
    nxt_up_due = up_due_ff;
    nxt_dn_due = dn_due_ff;
    for (int i = 0; i < NUM_KEYS; i++) begin
      nxt_key[i] = key_ff[i];
    end
    if (st_ff == ST_PROC) begin
      k = key_ff[sel_ff];
      // a fresh reference is taken from each burst during calibration and until recal runs out
      if (!cal_done_ff || k.recal != 3'h0) begin
        k.ref_lvl = burst_ff;
        k.integ   = 2'h0;
        k.det     = 1'b0;
        if (k.recal != 3'h0) begin
          k.recal = k.recal - 3'h1;
        end
      end else begin
        thr = (k.ref_lvl > THRESH) ? k.ref_lvl - THRESH : 12'h000;
        if (k.det) begin
          if (burst_ff > thr + HYST) begin
            k.det   = 1'b0;
            k.integ = 2'h0;
          end
        end else if (burst_ff < thr) begin
          // judged against the reference as it is now, new or drifted
          if (k.integ == INTEG_LAST) begin
            k.det   = 1'b1;
            k.integ = 2'h0;
          end else begin
            k.integ = k.integ + 2'h1;
          end
        end else begin
          k.integ = 2'h0;
          // one step per tick at most; a falling signal waits far longer
          if (burst_ff > k.ref_lvl && up_due_ff[sel_ff]) begin
            k.ref_lvl = k.ref_lvl + 12'h001;
          end else if (burst_ff < k.ref_lvl && dn_due_ff[sel_ff]) begin
            k.ref_lvl = k.ref_lvl - 12'h001;
          end
        end
      end
      nxt_key[sel_ff]        = k;
      nxt_up_due[sel_ff]     = 1'b0;
      nxt_dn_due[sel_ff]     = 1'b0;
    end
    // a tick in the clearing cycle still counts
    if (up_cnt_ff == 32'h0) begin
      nxt_up_due = 4'hF;
    end
    if (dn_cnt_ff == 32'h0) begin
      nxt_dn_due = 4'hF;
    end
    // the timer counts clocks of unbroken detection; only the timed-out key
    // is recalibrated, its neighbours keep their state
    for (int i = 0; i < NUM_KEYS; i++) begin
      nxt_on[i] = key_ff[i].det ? on_ff[i] + 32'h1 : 32'h0;
      if (key_ff[i].det && on_ff[i] >= tout) begin
        nxt_key[i].recal = RECAL_BURSTS;
        nxt_key[i].det   = 1'b0;
        nxt_key[i].integ = 2'h0;
        nxt_on[i]        = 32'h0;
      end
    end
    // keep earlier reports first, then admit new ones while room remains
    nxt_rep = 4'h0;
    for (int i = 0; i < NUM_KEYS; i++) begin
      if (rep_ff[i] && nxt_key[i].det && cnt < lim) begin
        nxt_rep[i] = 1'b1;
        cnt        = cnt + 2'h1;
      end
    end
    for (int i = 0; i < NUM_KEYS; i++) begin
      if (!rep_ff[i] && nxt_key[i].det && cnt < lim) begin
        nxt_rep[i] = 1'b1;
        cnt        = cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_KEYS; i++) begin
        key_ff[i] <= '0;
        on_ff[i]  <= 32'h0;
      end
      up_due_ff <= 4'h0;
      dn_due_ff <= 4'h0;
      up_cnt_ff <= 32'h1;
      dn_cnt_ff <= 32'h1;
      rep_ff    <= 4'h0;
    end else if (clk_en) begin
      for (int i = 0; i < NUM_KEYS; i++) begin
        key_ff[i] <= nxt_key[i];
        on_ff[i]  <= nxt_on[i];
      end
      up_due_ff <= nxt_up_due;
      dn_due_ff <= nxt_dn_due;
      up_cnt_ff <= nxt_up_cnt;
      dn_cnt_ff <= nxt_dn_cnt;
      rep_ff    <= nxt_rep;
    end
  end

  assign x_drive = x_ff;
  assign x_oe_n  = oe_n_ff;
  assign sw_s1   = sw_ff.s1;
  assign sw_s2   = sw_ff.s2;
  assign sw_s3   = sw_ff.s3;
  assign key_out = rep_ff;

endmodule
`default_nettype wire

/* tks_properties.sv */
// pin-level assertions for the touch key processor
`timescale 1ns/1ps
`default_nettype none
module tks_props #(
  parameter int unsigned CAL_CYCLES = 2000
) (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       rollover_select_pin,
  input wire logic [3:0] x_drive,
  input wire logic       x_oe_n,
  input wire logic       sw_s1,
  input wire logic       sw_s2,
  input wire logic       sw_s3,
  input wire logic [3:0] key_out
);
  logic [3:0]  last_x_ff;
  logic [3:0]  nxt_last_x;
  logic [31:0] cal_ff;
  logic [31:0] nxt_cal;
  always_comb begin
    nxt_last_x = (|x_drive) ? x_drive : last_x_ff;
    nxt_cal    = (cal_ff < CAL_CYCLES) ? cal_ff + 32'h1 : cal_ff;
  end
  always_ff @(posedge core_clk) begin
    last_x_ff <= rst_n ? nxt_last_x : 4'h0;
    cal_ff    <= rst_n ? nxt_cal : 32'h0;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  cal_quiet_a: assert property (cal_ff < CAL_CYCLES |-> key_out == 4'h0)
    else $error("touch during calibration");
  oe_run_a: assert property ($past(rst_n) |-> !x_oe_n)
    else $error("drive lines released");
  xdrv_gate_a: assert property (|x_drive |-> $onehot(x_drive) && (sw_s1 || sw_s2))
    else $error("bad drive phase");
  xhi_xfer_a: assert property (|x_drive && sw_s1 |=> x_drive == $past(x_drive) && sw_s2)
    else $error("no transfer phase");
  xfer_xlo_a: assert property (|x_drive && sw_s2 |=> x_drive == 4'h0 && sw_s2)
    else $error("no drive-low phase");
  scan_order_a:
    assert property (|x_drive && last_x_ff != 4'h0 && x_drive != last_x_ff
      |-> x_drive == {last_x_ff[2:0], last_x_ff[3]}) else $error("scan order");
  roll_one_a: assert property (!rollover_select_pin |-> $onehot0(key_out))
    else $error("two keys in single mode");
  roll_two_a: assert property ($countones(key_out) <= 2)
    else $error("over two keys");
  disch_idle_a: assert property (sw_s3 |-> x_drive == 4'h0 && !sw_s1 && !sw_s2)
    else $error("drive during discharge");
endmodule
bind tks_touch_key_signal_processor tks_props #(.CAL_CYCLES(CAL_CYCLES)) u_props (
  .core_clk(core_clk), .rst_n(rst_n), .rollover_select_pin(rollover_select_pin),
  .x_drive(x_drive), .x_oe_n(x_oe_n), .sw_s1(sw_s1), .sw_s2(sw_s2), .sw_s3(sw_s3),
  .key_out(key_out));
`default_nettype wire

/* tks_electrodes.sv */
// electrode matrix and shared sampling capacitor model
`timescale 1ns/1ps
`default_nettype none
module tks_electrodes (
  input  wire logic       core_clk,
  input  wire logic [3:0] x_drive,
  input  wire logic       sw_s2,
  input  wire logic       sw_s3,
  input  wire logic [3:0] touch,
  output logic            cs_trip
);
  int         cnt = 0;
  logic [3:0] sel = 4'h0;
  always @(posedge core_clk) begin
    if (sw_s3) cnt <= 0;
    else if (sw_s2 && |x_drive) begin
      cnt <= cnt + 1;
      sel <= x_drive;
    end
  end
  // a finger drains coupled charge, so a touched key trips sooner; level holds until discharge
  assign cs_trip = cnt >= ((|(sel & touch)) ? 12 : 20);
endmodule
`default_nettype wire

/* touch_key_signal_processor_tb.sv */
// self-checking bench for the touch key processor
`timescale 1ns/1ps
`default_nettype none
module touch_key_signal_processor_tb;
  localparam int TS = 3000;
  localparam int TL = 6000;
  logic       core_clk = 1'b0;
  logic       rst_n    = 1'b0;
  logic       roll     = 1'b1;
  logic       tsel     = 1'b1;
  logic [3:0] touch    = 4'h0;
  logic       cs_trip, sw_s2, sw_s3;
  logic [3:0] x_drive, key_out;
  int         n_mismatch = 0, samples_checked = 0, cyc = 0, t0;
  // upward drift fast enough to be seen within a few bursts; downward slowed past the run
  tks_touch_key_signal_processor #(.CAL_CYCLES(2000), .TOUT_SHORT(TS), .TOUT_LONG(TL),
    .DRIFT_UP_PER(50), .DRIFT_DN_PER(100000)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1), .cs_trip(cs_trip),
    .rollover_select_pin(roll), .timeout_select_pin(tsel), .x_drive(x_drive),
    .x_oe_n(), .sw_s1(), .sw_s2(sw_s2), .sw_s3(sw_s3), .key_out(key_out));
  tks_electrodes elec (.core_clk(core_clk), .x_drive(x_drive), .sw_s2(sw_s2),
    .sw_s3(sw_s3), .touch(touch), .cs_trip(cs_trip));
  initial forever #50 core_clk = ~core_clk;
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_in(input string what, input int lo, input int hi, input int got);
    samples_checked++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  // returns while the next key bursts, so touch changes never split a burst of key k
  task automatic bursts(input int k, input int n);
    repeat (n) begin
      wait (x_drive[k]);
      wait (x_drive[(k + 1) % 4]);
    end
    @(negedge core_clk);
  endtask
  task automatic t_integ();
    bursts(2, 1);
    touch = 4'h4;
    bursts(2, 2);
    chk("two samples", 4'h0, key_out);
    touch = 4'h0;
    bursts(2, 1);
    touch = 4'h4;
    bursts(2, 2);
    chk("cleared count", 4'h0, key_out);
    bursts(2, 1);
    chk("third sample", 4'h4, key_out);
    touch = 4'h0;
    bursts(2, 1);
    chk("release", 4'h0, key_out);
    $display("integrator test done");
  endtask
  task automatic t_roll();
    roll = 1'b0;
    bursts(2, 1);
    touch = 4'h6;
    bursts(2, 4);
    chk("single key", 4'h2, key_out);
    touch = 4'h0;
    bursts(2, 1);
    roll = 1'b1;
    touch = 4'h2;
    bursts(1, 4);
    touch = 4'hA;
    bursts(3, 4);
    touch = 4'hB;
    bursts(0, 4);
    chk("two keys", 4'hA, key_out);
    touch = 4'h0;
    bursts(0, 2);
    $display("rollover test done");
  endtask
  task automatic t_tout(input logic sel, input int k, input int lim);
    tsel = sel;
    bursts(k, 1);
    touch[k] = 1'b1;
    wait (key_out[k]);
    t0 = cyc;
    @(negedge core_clk);
    if (k == 0) begin
      touch[2] = 1'b1;
      bursts(2, 4);
    end
    wait (!key_out[k]);
    @(negedge core_clk);
    chk_in("on time", lim - 8, lim + 8, cyc - t0);
    chk("other key", (k == 0) ? 4'h4 : 4'h0, key_out);
    touch[2] = 1'b0;
    bursts(k, 8);
    chk("after recal", 4'h0, key_out);
    touch = 4'h0;
    bursts(k, 10);
    touch[k] = 1'b1;
    bursts(k, 3);
    chk("drift up", (k == 0) ? 4'h1 : 4'h8, key_out);
    touch = 4'h0;
    bursts(k, 1);
    $display("timeout test done");
  endtask
  initial begin
    repeat (6) @(negedge core_clk);
    rst_n = 1'b1;
    chk("after reset", 4'h0, key_out);
    repeat (2100) @(negedge core_clk);
    t_integ();
    t_roll();
    t_tout(1'b0, 0, TS);
    t_tout(1'b1, 3, TL);
    test_done();
  end
endmodule
`default_nettype wire
